// ### hdl/basic_timer.sv
// Basic timer: counter, prescaler, auto-reload and update event logic.
// Assumes a register master per the strobe port; trigger pin is async.
`timescale 1ns/1ns

module basic_timer
	import basic_timer_pkg::*;
(
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic slave_trigger_input_in,
	output logic update_irq_out,
	output logic update_dma_req_out,
	output logic update_event_out
);
	typedef enum logic [1:0] {
		DIR_UP = 2'b00,
		DIR_DOWN = 2'b01
	} dir_t;

	logic [31:0] control_one;
	logic [31:0] slave_ctrl;
	logic [31:0] irq_dma_enable_reg;
	logic [31:0] irq_mask;
	logic update_pending_flag;
	logic force_update;
	logic [31:0] count_value;
	logic [15:0] prescale_divider;
	logic [15:0] active_prescale;
	logic [15:0] prescale_count;
	logic [31:0] reload_limit;
	logic [31:0] active_reload;
	logic [2:0] trig_sync;
	logic trig_level;
	logic update_disable;
	logic update_source_select;
	logic count_down;
	logic centered;
	logic slave_reset_mode;
	logic trig_rise;
	logic reinit;
	logic tick;
	logic overflow;
	logic update_event;
	logic flag_set;
	logic wr_status_clear;
	dir_t dir;

	assign update_disable = control_one[UPDATE_DISABLE_BIT];
	assign update_source_select = control_one[UPDATE_SOURCE_BIT];
	assign centered = |control_one[CENTER_LSB+1:CENTER_LSB];
	assign dir = (control_one[DIRECTION_BIT] && !centered) ? DIR_DOWN
		: DIR_UP;
	assign count_down = (dir == DIR_DOWN);
	assign slave_reset_mode =
		slave_ctrl[SLAVE_MODE_LSB+2:SLAVE_MODE_LSB] == SLAVE_MODE_RESET;

	// ------------------------------------------------------------
	// Trigger input synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			trig_sync <= 3'h0;
		end else begin
			trig_sync <= {trig_sync[1:0], slave_trigger_input_in};
		end
	end

	// Level only moves once the second and third stages agree
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			trig_level <= 1'b0;
		end else if (trig_sync[1] == trig_sync[2]) begin
			trig_level <= trig_sync[2];
		end
	end

	assign trig_rise = slave_reset_mode && (trig_sync[1] == trig_sync[2])
		&& trig_sync[2] && !trig_level;

	// ------------------------------------------------------------
	// Event sources
	// ------------------------------------------------------------
	assign reinit = force_update || trig_rise;
	assign tick = (active_reload != REG_RESET)
		&& (prescale_count == active_prescale);
	assign overflow = tick && !reinit && (count_down
		? (count_value == REG_RESET)
		: (count_value >= active_reload));
	// Update disable suppresses every kind of update
	assign update_event = !update_disable && (reinit || overflow);
	assign flag_set = !update_disable && (overflow
		|| (reinit && !update_source_select));
	assign wr_status_clear = wr_in && (addr_in == UPDATE_STATUS_ADDR)
		&& !wdata_in[UPDATE_FLAG_BIT];

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			control_one <= REG_RESET;
			slave_ctrl <= REG_RESET;
			irq_dma_enable_reg <= REG_RESET;
			irq_mask <= REG_RESET;
			prescale_divider <= PRESCALE_RESET;
			reload_limit <= REG_RESET;
		end else if (wr_in) begin
			case (addr_in)
			CONTROL_ONE_ADDR: control_one <= wdata_in;
			SLAVE_CTRL_ADDR: slave_ctrl <= wdata_in;
			IRQ_DMA_ENABLE_ADDR: irq_dma_enable_reg <= wdata_in;
			IRQ_MASK_ADDR: irq_mask <= wdata_in;
			PRESCALE_DIVIDER_ADDR: prescale_divider <= wdata_in[15:0];
			RELOAD_LIMIT_ADDR: reload_limit <= wdata_in;
			default: ;
			endcase
		end
	end

	// Self clearing; a write of zero leaves it alone
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			force_update <= 1'b0;
		end else begin
			force_update <= wr_in && (addr_in == EVENT_TRIGGER_ADDR)
				&& wdata_in[FORCE_UPDATE_BIT];
		end
	end

	// Shadow copies only move at update events
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			active_prescale <= PRESCALE_RESET;
			active_reload <= REG_RESET;
		end else if (update_event) begin
			active_prescale <= prescale_divider;
			active_reload <= reload_limit;
		end
	end

	// Set beats a simultaneous software clear
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			update_pending_flag <= 1'b0;
		end else if (flag_set) begin
			update_pending_flag <= 1'b1;
		end else if (wr_status_clear) begin
			update_pending_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Prescaler and counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			prescale_count <= PRESCALE_RESET;
		end else if (reinit || tick || active_reload == REG_RESET) begin
			prescale_count <= PRESCALE_RESET;
		end else begin
			prescale_count <= prescale_count + 16'h1;
		end
	end

	// Reinit uses the new reload value when counting down
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			count_value <= REG_RESET;
		end else if (reinit) begin
			count_value <= count_down ? reload_limit : REG_RESET;
		end else if (wr_in && addr_in == COUNT_VALUE_ADDR) begin
			count_value <= wdata_in;
		end else if (overflow) begin
			count_value <= count_down ? active_reload : REG_RESET;
		end else if (tick) begin
			count_value <= count_down ? count_value - 32'h1
				: count_value + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// Read port and outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rdata_out <= REG_RESET;
		end else if (rd_in) begin
			case (addr_in)
			CONTROL_ONE_ADDR: rdata_out <= control_one;
			SLAVE_CTRL_ADDR: rdata_out <= slave_ctrl;
			IRQ_DMA_ENABLE_ADDR: rdata_out <= irq_dma_enable_reg;
			UPDATE_STATUS_ADDR: rdata_out <= {31'h0, update_pending_flag};
			EVENT_TRIGGER_ADDR: rdata_out <= REG_RESET;
			COUNT_VALUE_ADDR: rdata_out <= count_value;
			PRESCALE_DIVIDER_ADDR: rdata_out <= {16'h0, prescale_divider};
			RELOAD_LIMIT_ADDR: rdata_out <= reload_limit;
			IRQ_MASK_ADDR: rdata_out <= irq_mask;
			default: rdata_out <= REG_RESET;
			endcase
		end else begin
			rdata_out <= REG_RESET;
		end
	end

	// Mask bit set silences the line; clear from reset so enable alone rules
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			update_irq_out <= 1'b0;
			update_dma_req_out <= 1'b0;
			update_event_out <= 1'b0;
		end else begin
			update_irq_out <= update_pending_flag
				&& irq_dma_enable_reg[IRQ_ENABLE_BIT]
				&& !irq_mask[IRQ_ENABLE_BIT];
			update_dma_req_out <= flag_set
				&& irq_dma_enable_reg[DMA_ENABLE_BIT];
			update_event_out <= update_event;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_flag_sets: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		flag_set |=> update_pending_flag
	) else $error("flag not set after event");

	chk_flag_holds: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(update_pending_flag && !wr_status_clear) |=> update_pending_flag
	) else $error("flag dropped without a clear");

	chk_ovf_disable: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(overflow && update_disable && !update_pending_flag)
		|=> !update_pending_flag
	) else $error("flag set while updates disabled");

	chk_force_source: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(force_update && update_source_select && !update_pending_flag)
		|=> !update_pending_flag
	) else $error("forced update set flag with source select");

	chk_trig_flag: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(trig_rise && !update_source_select && !update_disable)
		|=> update_pending_flag
	) else $error("trigger reinit missed flag");

	chk_force_clears: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		force_update |=> !force_update || $past(wr_in)
	) else $error("force update stuck");

	chk_force_reinit: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(force_update && !count_down)
		|=> (count_value == 32'h0) && (prescale_count == 16'h0)
	) else $error("force update did not reinit");

	chk_force_down: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(force_update && count_down) |=> count_value == $past(reload_limit)
	) else $error("downward reinit missed reload value");

	chk_prescale_hold: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		!update_event |=> $stable(active_prescale)
	) else $error("prescaler moved without update");

	chk_stopped_zero: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(active_reload == 32'h0 && !reinit && !wr_in)
		|=> $stable(count_value)
	) else $error("counter ran with zero reload");

	chk_irq_quiet: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		!irq_dma_enable_reg[IRQ_ENABLE_BIT] |=> !update_irq_out
	) else $error("interrupt raised while disabled");

	chk_dma_gate: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		update_dma_req_out |-> $past(flag_set)
		&& $past(irq_dma_enable_reg[DMA_ENABLE_BIT])
	) else $error("DMA request without enabled update");

	chk_disable_block: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		update_disable |-> !update_event
	) else $error("update while disabled");

	chk_preload_frozen: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		update_disable |=> $stable(active_reload)
	) else $error("reload copied while updates disabled");

	chk_wrap_zero: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(overflow && !count_down && !wr_in) |=> count_value == 32'h0
	) else $error("upward overflow did not wrap");

	chk_irq_gate: assert property (
		@(posedge clk_in) disable iff (!rstn_in)
		(update_pending_flag && irq_dma_enable_reg[IRQ_ENABLE_BIT]
		&& !irq_mask[IRQ_ENABLE_BIT]) |=> update_irq_out
	) else $error("interrupt missing");

	cov_overflow: cover property (@(posedge clk_in) disable iff (!rstn_in)
		overflow && !count_down);
	cov_force: cover property (@(posedge clk_in) disable iff (!rstn_in)
		force_update ##1 update_pending_flag);
	cov_trigger: cover property (@(posedge clk_in) disable iff (!rstn_in)
		trig_rise);
	cov_irq: cover property (@(posedge clk_in) disable iff (!rstn_in)
		update_irq_out);
	cov_dma: cover property (@(posedge clk_in) disable iff (!rstn_in)
		update_dma_req_out);
endmodule // basic_timer

// ### hdl/basic_timer_pkg.sv
// Constants for the basic timer update, counter and prescaler block.
// Assumes a 10 MHz functional clock and a simple strobe register port.
package basic_timer_pkg;
	localparam logic [7:0] CONTROL_ONE_ADDR = 8'h00;
	localparam logic [7:0] SLAVE_CTRL_ADDR = 8'h08;
	localparam logic [7:0] IRQ_DMA_ENABLE_ADDR = 8'h0C;
	localparam logic [7:0] UPDATE_STATUS_ADDR = 8'h10;
	localparam logic [7:0] EVENT_TRIGGER_ADDR = 8'h14;
	localparam logic [7:0] COUNT_VALUE_ADDR = 8'h24;
	localparam logic [7:0] PRESCALE_DIVIDER_ADDR = 8'h28;
	localparam logic [7:0] RELOAD_LIMIT_ADDR = 8'h2C;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h30;
	localparam int UPDATE_DISABLE_BIT = 1;
	localparam int UPDATE_SOURCE_BIT = 2;
	localparam int DIRECTION_BIT = 4;
	localparam int CENTER_LSB = 5;
	localparam int FORCE_UPDATE_BIT = 0;
	localparam int UPDATE_FLAG_BIT = 0;
	localparam int IRQ_ENABLE_BIT = 0;
	localparam int DMA_ENABLE_BIT = 8;
	localparam int SLAVE_MODE_LSB = 16;
	localparam logic [2:0] SLAVE_MODE_RESET = 3'h1;
	localparam logic [31:0] REG_RESET = 32'h0;
	localparam logic [15:0] PRESCALE_RESET = 16'h0;
endpackage

// ### verification/testbench.sv
// Self-checking bench for the basic timer update and counter block.
// Assumes the strobe register port and package offsets of the design.
`timescale 1ns/1ns
module testbench;
	import basic_timer_pkg::*;
	logic clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
	logic slave_trigger_input_in = 1'b0;
	logic [7:0] addr_in = 8'h00;
	logic [31:0] wdata_in = 32'h0, rdata_out, r;
	logic update_irq_out, update_dma_req_out, update_event_out;
	logic [7:0] al [6];
	int fails = 0, checks = 0, cyc = 0, seed = 13, dmas = 0, d0;
	int evq [$];
	always #50 clk_in = ~clk_in;
	basic_timer DUT (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.addr_in(addr_in),
		.wdata_in(wdata_in),
		.wr_in(wr_in),
		.rd_in(rd_in),
		.rdata_out(rdata_out),
		.slave_trigger_input_in(slave_trigger_input_in),
		.update_irq_out(update_irq_out),
		.update_dma_req_out(update_dma_req_out),
		.update_event_out(update_event_out)
	);
	// ----------------------------------------
	// Event log and watchdog
	// ----------------------------------------
	always @(posedge clk_in) begin
		cyc++;
		if (update_event_out === 1'b1) evq.push_back(cyc);
		if (update_dma_req_out === 1'b1) dmas++;
		if (cyc == 30000) begin
			fails++;
			end_of_test();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string n);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#10 chk(n, e, rdata_out);
	endtask
	// Forced update, then let the reinit land before anything is read
	task automatic fu();
		wr(EVENT_TRIGGER_ADDR, 32'h1);
		repeat (3) @(posedge clk_in);
	endtask
	// Model: one period is (reload + 1) * (prescale + 1) clocks
	task automatic period(input int a, input int p);
		evq = {};
		while (evq.size() < 3) @(posedge clk_in);
		chk("period", (a + 1) * (p + 1), evq[2] - evq[1]);
	endtask
	task automatic trig(input logic [31:0] ev, input logic [31:0] st);
		wr(UPDATE_STATUS_ADDR, 32'h0);
		evq = {};
		@(posedge clk_in);
		slave_trigger_input_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		// Drop the pin so the next call makes a fresh rising edge
		slave_trigger_input_in <= 1'b0;
		chk("trigger events", ev, evq.size());
		rd(UPDATE_STATUS_ADDR, st, "trigger flag");
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		al = '{COUNT_VALUE_ADDR, PRESCALE_DIVIDER_ADDR, RELOAD_LIMIT_ADDR,
			EVENT_TRIGGER_ADDR, UPDATE_STATUS_ADDR, 8'h40};
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		foreach (al[i]) rd(al[i], 32'h0, "reset value");
		// Working reload is still zero, so the counter holds
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			wr(al[i % 3], r);
			// Only the low half of the prescale word exists
			if (i % 3 == 1) r[31:16] = 16'h0;
			rd(al[i % 3], r, "readback");
		end
		rd(COUNT_VALUE_ADDR, r, "count held");
		wr(IRQ_DMA_ENABLE_ADDR, 32'h101);
		wr(RELOAD_LIMIT_ADDR, 32'h5);
		wr(PRESCALE_DIVIDER_ADDR, 32'h0000FFFF);
		evq = {};
		for (int m = 0; m < 3; m++) begin
			wr(CONTROL_ONE_ADDR, 32'h1 << (m + 3) & 32'h30);
			fu();
			rd(COUNT_VALUE_ADDR, (m == 1) ? 32'h5 : 32'h0, "reinit");
		end
		chk("forced events", 32'h3, evq.size());
		chk("dma pulses", 32'h3, dmas);
		chk("irq on", 32'h1, update_irq_out);
		wr(IRQ_MASK_ADDR, 32'h1);
		repeat (2) @(posedge clk_in);
		chk("irq masked", 32'h0, update_irq_out);
		wr(IRQ_MASK_ADDR, 32'h0);
		wr(IRQ_DMA_ENABLE_ADDR, 32'h100);
		repeat (2) @(posedge clk_in);
		chk("irq disabled", 32'h0, update_irq_out);
		wr(IRQ_DMA_ENABLE_ADDR, 32'h101);
		wr(UPDATE_STATUS_ADDR, 32'h0);
		repeat (2) @(posedge clk_in);
		chk("irq cleared", 32'h0, update_irq_out);
		wr(CONTROL_ONE_ADDR, 32'h1 << UPDATE_SOURCE_BIT);
		evq = {};
		d0 = dmas;
		fu();
		chk("source event", 32'h1, evq.size());
		rd(UPDATE_STATUS_ADDR, 32'h0, "source flag");
		chk("source dma", d0, dmas);
		// Disabled updates: new limits must not be taken
		wr(CONTROL_ONE_ADDR, 32'h1 << UPDATE_DISABLE_BIT);
		wr(RELOAD_LIMIT_ADDR, 32'h3);
		wr(PRESCALE_DIVIDER_ADDR, 32'h2);
		evq = {};
		fu();
		chk("disabled events", 32'h0, evq.size());
		rd(UPDATE_STATUS_ADDR, 32'h0, "disabled flag");
		wr(CONTROL_ONE_ADDR, 32'h0);
		fu();
		period(3, 2);
		wr(PRESCALE_DIVIDER_ADDR, 32'h0);
		period(3, 0);
		rd(UPDATE_STATUS_ADDR, 32'h1, "overflow flag");
		wr(CONTROL_ONE_ADDR, 32'h1 << UPDATE_DISABLE_BIT);
		wr(UPDATE_STATUS_ADDR, 32'h0);
		evq = {};
		repeat (20) @(posedge clk_in);
		chk("overflow gated", 32'h0, evq.size());
		rd(UPDATE_STATUS_ADDR, 32'h0, "gated flag");
		wr(CONTROL_ONE_ADDR, 32'h0);
		wr(RELOAD_LIMIT_ADDR, 32'h0);
		fu();
		wr(SLAVE_CTRL_ADDR, 32'h1 << SLAVE_MODE_LSB);
		trig(32'h1, 32'h1);
		wr(CONTROL_ONE_ADDR, 32'h1 << UPDATE_SOURCE_BIT);
		trig(32'h1, 32'h0);
		// Slave mode off: the same edge must raise no update event and no flag
		wr(SLAVE_CTRL_ADDR, 32'h0);
		trig(32'h0, 32'h0);
		end_of_test();
	end
endmodule // testbench
